// >>> host_mcu_model.sv
`default_nettype none
module host_mcu_model
    import mcu_memory_system_pkg::*;
(
    // Clock
    input wire logic             pclk,
    // Strobes and address towards the device
    output logic                 ale,
    output logic                 rd_n,
    output logic                 wr_n,
    output logic                 psen_n,
    output logic [7:0]           lad,
    output logic [7:0]           hi,
    // From the device
    input wire logic [7:0]       lad_o,
    input wire logic             lad_oe_n,
    input wire logic [N_SEL-1:0] sel
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {ale, rd_n, wr_n, psen_n, lad, hi} = {4'h7, 16'h0000};
    end
    task automatic addr_phase(input logic [15:0] a);
        @(posedge pclk);
        ale <= 1'b1;
        lad <= a[7:0];
        hi <= a[15:8];
        repeat (4) @(posedge pclk);
        ale <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d,
                      output logic [N_SEL-1:0] s, output logic ok);
        int n = 0;
        addr_phase(a);
        // Released bus shows the inverse, never a stale value
        lad <= ~a[7:0];
        rd_n <= 1'b0;
        while (lad_oe_n !== 1'b0 && n < 12) begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(posedge pclk);
        ok = (lad_oe_n === 1'b0);
        d = lad_o;
        s = sel;
        rd_n <= 1'b1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        addr_phase(a);
        lad <= d;
        wr_n <= 1'b0;
        repeat (4) @(posedge pclk);
        wr_n <= 1'b1;
        // Write lands late: hold data past the synchroniser lag
        repeat (5) @(posedge pclk);
        lad <= ~d;
    endtask
endmodule
`default_nettype wire

// >>> mcu_memory_system_core.sv
`default_nettype none
module mcu_memory_system_core
    import mcu_memory_system_pkg::*;
(
    // APB
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Host bus
    input  wire logic              ale,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic              psen_n,
    input  wire logic [7:0]        low_addr_data_port_i,
    output logic [7:0]             low_addr_data_port_o,
    output logic                   low_addr_data_port_oe_n,
    input  wire logic [7:0]        high_addr_port,
    // Test port enable strap
    input  wire logic              tp_enable,
    // Memories
    input  wire logic [7:0]        mem_rdata,
    output logic [N_SEL-1:0]       int_sel,
    output logic [1:0]             flash_busy,
    // Pins and logic
    input  wire logic [N_PINS-1:0] pin_i,
    output logic [N_PINS-1:0]      pin_o,
    output logic [N_PINS-1:0]      pin_oe_n,
    output logic [N_ULA-1:0]       ula_out,
    output logic                   power_down
);

    typedef struct packed {
        logic [N_SYNC-1:0]             s1;
        logic [N_SYNC-1:0]             s2;
        logic [N_SYNC-1:0]             prev;
        logic [15:0]                   addr;
        logic [7:0]                    page;
        logic                          turbo;
        logic [7:0]                    blk;
        logic [31:0]                   base;
        logic [2:0]                    mode;
        logic [N_PINS-1:0][1:0]        pmode;
        logic [N_PINS-1:0]             pout;
        logic [7:0]                    tsel;
        logic [N_TERM-1:0][N_LIN-1:0]  tmask;
        logic [N_TERM-1:0][N_LIN-1:0]  tmatch;
        logic [N_TERM-1:0][4:0]        tout;
        logic [N_LIN-1:0]              lprev;
        logic [N_ULA-1:0]              ula;
        logic [N_SEL-1:0]              sel;
        logic [7:0]                    rdd;
        logic [31:0]                   prd;
        logic [1:0]                    busy;
        logic [15:0]                   cnt_main;
        logic [15:0]                   cnt_boot;
        logic                          err;
        logic [15:0]                   idle;
        logic                          pdown;
        logic [N_PINS-1:0]             po;
        logic [N_PINS-1:0]             poe_n;
    } state_s;

    state_s r;
    state_s nxt;

    function automatic logic [7:0] onehot8(input logic [2:0] i);
        onehot8 = 8'h01 << i;
    endfunction

    // ======================================================
    // Synchronised pin view
    logic              s_tpen;
    logic              s_psen_n;
    logic              s_wr_n;
    logic              s_rd_n;
    logic              s_ale;
    logic [7:0]        s_hi;
    logic [7:0]        s_lo;
    logic [N_PINS-1:0] s_pin;
    logic              wr_rise;
    logic              ale_fall;
    logic [15:0]       cur_addr;
    logic [7:0]        host_data;
    logic [N_LIN-1:0]  lbus;
    logic [N_LIN-1:0]  lmask;
    logic [N_SEL-1:0]  dec;
    logic [N_ULA-1:0]  ula_c;
    logic [7:0]        hrd;
    logic [7:0]        status;
    logic              cfg_ok;
    logic              a_setup;
    logic              a_wr;
    logic              a_hit;
    logic              host_rd;
    logic [4:0]        a_idx;

    assign {s_tpen, s_psen_n, s_wr_n, s_rd_n, s_ale, s_hi, s_lo,
            s_pin} = r.s2;
    assign wr_rise  = s_wr_n & ~r.prev[N_SYNC-3];
    assign ale_fall = ~s_ale & r.prev[N_SYNC-5];
    // Non-multiplexed hosts keep the address on the pins
    assign cur_addr = r.mode[M_NONMUX] ? {s_hi, s_lo} : r.addr;
    assign host_data = r.mode[M_NONMUX]
        ? {s_pin[P_G0+3:P_G0], s_pin[P_F0+3:P_F0]} : s_lo;
    assign host_rd = ~s_rd_n | ~s_psen_n;
    // Configuration writes only while the test port owns the device
    assign cfg_ok = s_tpen;
    assign status = {3'h0, r.pdown, r.err, r.busy, r.turbo};

    // ======================================================
    // Shared logic input bus
    assign lbus = {r.page, cur_addr, host_rd, ~s_wr_n, ~s_psen_n,
                   s_pin[38:0]};
    always_comb begin
        lmask = '1;
        if (r.blk[0]) lmask[65:58] = '0;
        if (r.blk[1]) lmask[49:42] = '0;
        if (r.blk[2]) lmask[57:50] = '0;
        if (r.blk[3]) lmask[41:39] = '0;
        if (r.blk[4]) lmask[7:0]   = '0;
        if (r.blk[5]) lmask[15:8]  = '0;
        if (r.blk[6]) lmask[23:16] = '0;
        if (r.blk[7]) lmask[38:24] = '0;
    end

    // ======================================================
    // Internal select decoder; priority keeps the selects one-hot
    always_comb begin
        dec = '0;
        if (cur_addr[15:8] == r.base[31:24]) begin
            if (cur_addr[7]) dec[S_PORT] = 1'b1;
            else dec[S_REG] = 1'b1;
        end else if (cur_addr[15:13] == 3'h1) begin
            dec[S_SRAM] = 1'b1;
        end else if (r.page == r.base[15:8] && cur_addr[15:14] == 2'h1)
        begin
            dec[S_BOOT +: 4] =
                4'(onehot8({1'b0, cur_addr[13:12]}));
        end else if (r.page == r.base[7:0] && cur_addr[15]) begin
            dec[S_MAIN +: 8] = onehot8(cur_addr[14:12]);
        end
    end

    // ======================================================
    // User logic array
    always_comb begin
        ula_c = '0;
        for (int t = 0; t < N_TERM; t++) begin
            if ((((lbus & lmask) ^ r.tmatch[t]) & r.tmask[t]) == '0 &&
                r.tout[t] < 5'(N_ULA))
                ula_c[r.tout[t]] = 1'b1;
        end
    end

    // ======================================================
    // Host read data
    always_comb begin
        hrd = mem_rdata;
        if (r.sel[S_REG]) begin
            case (cur_addr[2:0])
                H_PAGE:  hrd = r.page;
                H_PWR:   hrd = {7'h0, r.turbo};
                H_BLK:   hrd = r.blk;
                H_STAT:  hrd = status;
                default: hrd = 8'h00;
            endcase
        end else if (r.sel[S_PORT]) begin
            // Padded so the short last port reads zeros above its pins
            hrd = 8'({4'h0, s_pin} >> {cur_addr[2:0], 3'h0});
        end
    end

    // ======================================================
    // APB decode
    assign a_setup = psel & ~penable;
    assign a_wr    = psel & penable & pwrite;
    assign a_idx   = paddr[6:2];
    assign a_hit   = (paddr[1:0] == 2'h0) && (paddr <= A_TOUT);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (~a_hit |
                     (pwrite & paddr >= A_BASE & ~cfg_ok));

    // ======================================================
    // Next state
    always_comb begin
        nxt = r;
        nxt.s1   = {tp_enable, psen_n, wr_n, rd_n, ale, high_addr_port,
                    low_addr_data_port_i, pin_i};
        nxt.s2   = r.s1;
        nxt.prev = r.s2;
        nxt.lprev = lbus & lmask;
        if (ale_fall) nxt.addr = {s_hi, s_lo};
        nxt.sel = dec;
        nxt.rdd = hrd;
        // Turbo off: outputs refresh only on an input transition
        if (r.turbo || ((lbus & lmask) != r.lprev))
            nxt.ula = ula_c;

        // Flash engines run independently of each other
        for (int f = 0; f < 2; f++) begin
            if (f == 0 && r.busy[0]) begin
                nxt.cnt_main = r.cnt_main - 16'h1;
                if (r.cnt_main == 16'h1) nxt.busy[0] = 1'b0;
            end
            if (f == 1 && r.busy[1]) begin
                nxt.cnt_boot = r.cnt_boot - 16'h1;
                if (r.cnt_boot == 16'h1) nxt.busy[1] = 1'b0;
            end
        end

        // Host register writes
        if (wr_rise && r.sel[S_REG]) begin
            case (cur_addr[2:0])
                H_PAGE: nxt.page = host_data;
                H_PWR:  nxt.turbo = host_data[0];
                H_BLK:  nxt.blk = host_data;
                H_CMD: begin
                    if (host_data[0]) begin
                        if (r.busy[0]) nxt.err = 1'b1;
                        else begin
                            nxt.busy[0] = 1'b1;
                            nxt.cnt_main = FLASH_CYCLES;
                        end
                    end
                    if (host_data[1]) begin
                        if (r.busy[1]) nxt.err = 1'b1;
                        else begin
                            nxt.busy[1] = 1'b1;
                            nxt.cnt_boot = FLASH_CYCLES;
                        end
                    end
                end
                default: ;
            endcase
        end else if (wr_rise && r.sel[S_PORT] && cur_addr[2:0] < 3'h7) begin
            for (int b = 0; b < 8; b++) begin
                if (8 * int'(cur_addr[2:0]) + b < N_PINS)
                    nxt.pout[8 * int'(cur_addr[2:0]) + b] = host_data[b];
            end
        end

        // APB read data captured in setup for the access cycle
        if (a_setup) begin
            case (paddr)
                A_PAGE:  nxt.prd = {24'h0, r.page};
                A_PWR:   nxt.prd = {31'h0, r.turbo};
                A_BLK:   nxt.prd = {24'h0, r.blk};
                A_STAT:  nxt.prd = {24'h0, status};
                A_BASE:  nxt.prd = r.base;
                A_MODE:  nxt.prd = {29'h0, r.mode};
                A_TSEL:  nxt.prd = {24'h0, r.tsel};
                A_TMSKL: nxt.prd = r.tmask[r.tsel][31:0];
                A_TMSKH: nxt.prd = {r.tmask[r.tsel][65:64], 30'h0};
                A_TMATL: nxt.prd = r.tmatch[r.tsel][31:0];
                A_TMATH: nxt.prd = {r.tmatch[r.tsel][65:64], 30'h0};
                A_TOUT:  nxt.prd = {27'h0, r.tout[r.tsel]};
                default: nxt.prd = (paddr >= A_PMODE && paddr < A_TSEL)
                    ? 32'(r.pmode[13 * (a_idx - 5'h6) +: 13]) : 32'h0;
            endcase
        end

        // APB writes; term storage is masked to the populated range
        if (a_wr && a_hit) begin
            case (paddr)
                A_PAGE: nxt.page = pwdata[7:0];
                A_PWR:  nxt.turbo = pwdata[0];
                A_BLK:  nxt.blk = pwdata[7:0];
                A_STAT: if (pwdata[3]) nxt.err = 1'b0;
                default: ;
            endcase
            if (cfg_ok) begin
                case (paddr)
                    A_BASE:  nxt.base = pwdata;
                    A_MODE:  nxt.mode = pwdata[2:0];
                    A_TSEL:  nxt.tsel = pwdata[7:0];
                    A_TMSKL: nxt.tmask[r.tsel][31:0] = pwdata;
                    A_TMSKH: nxt.tmask[r.tsel][65:32] = {pwdata[31:30], 32'h0};
                    A_TMATL: nxt.tmatch[r.tsel][31:0] = pwdata;
                    A_TMATH: nxt.tmatch[r.tsel][65:32] = {pwdata[31:30], 32'h0};
                    A_TOUT:  nxt.tout[r.tsel] = pwdata[4:0];
                    default: begin
                        if (paddr >= A_PMODE && paddr < A_TSEL)
                            for (int k = 0; k < 13; k++)
                                if (13 * (a_idx - 5'h6) + k < N_PINS)
                                    nxt.pmode[13 * (a_idx - 5'h6) + k] =
                                        pwdata[2*k +: 2];
                    end
                endcase
            end
        end
        // A new error in the clearing cycle survives the clear
        if (wr_rise && r.sel[S_REG] && cur_addr[2:0] == H_CMD &&
            ((host_data[0] & r.busy[0]) | (host_data[1] & r.busy[1])))
            nxt.err = 1'b1;
        if (r.tsel >= 8'(N_TERM)) nxt.tsel = 8'h0;

        // Auto power-down on host inactivity
        if (host_rd || ~s_wr_n || s_ale || ~r.mode[M_APDEN]) begin
            nxt.idle  = 16'h0;
            nxt.pdown = 1'b0;
        end else if (r.idle == IDLE_CYCLES - 16'h1) begin
            nxt.pdown = 1'b1;
        end else begin
            nxt.idle = r.idle + 16'h1;
        end

        // Pin drivers
        for (int p = 0; p < N_PINS; p++) begin
            case (r.pmode[p])
                PM_OUT:  nxt.po[p] = r.pout[p];
                PM_ULA:  nxt.po[p] = r.ula[p % N_ULA];
                PM_ADDR: nxt.po[p] = cur_addr[p % 16];
                default: nxt.po[p] = 1'b0;
            endcase
            nxt.poe_n[p] = (r.pmode[p] == PM_IN) || r.pdown;
        end
        if (r.mode[M_TPEN]) begin
            nxt.po[P_BUSY]     = ~(|r.busy);
            nxt.po[P_FAIL]     = ~r.err;
            nxt.poe_n[P_BUSY]  = 1'b0;
            nxt.poe_n[P_FAIL]  = 1'b0;
            nxt.poe_n[35:32]   = 4'hF;
        end
        if (r.mode[M_NONMUX]) begin
            nxt.po[P_F0 +: 4] = r.rdd[3:0];
            nxt.po[P_G0 +: 4] = r.rdd[7:4];
            nxt.poe_n[P_F0 +: 4] = {4{~(host_rd & (|r.sel))}};
            nxt.poe_n[P_G0 +: 4] = {4{~(host_rd & (|r.sel))}};
        end
        // Power-down floats every pin, test port pins too
        if (r.pdown) nxt.poe_n = '1;
    end

    // ======================================================
    // State register; reset aborts flash work and returns configuration to reset values (BASE_RST, TOUT_RST, turbo on)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            // Idle pin levels: no false edge, no open config window
            r.s1       <= {5'h0E, 68'h0};
            r.s2       <= {5'h0E, 68'h0};
            r.prev     <= {5'h0E, 68'h0};
            r.turbo    <= 1'b1;
            r.base     <= BASE_RST;
            r.tout     <= {N_TERM{TOUT_RST}};
            r.po       <= '0;
            r.poe_n    <= '1;
        end else begin
            r <= nxt;
        end
    end

    // ======================================================
    // Outputs
    assign prdata     = r.prd;
    assign int_sel    = r.sel;
    assign flash_busy = r.busy;
    assign ula_out    = r.ula;
    assign power_down = r.pdown;
    assign pin_o      = r.po;
    assign pin_oe_n   = r.poe_n;
    assign low_addr_data_port_o = r.rdd;
    assign low_addr_data_port_oe_n =
        ~(host_rd & (|r.sel) & ~r.mode[M_NONMUX]);

endmodule
`default_nettype wire

// >>> mcu_memory_system_core_sva.sv
`default_nettype none
module mcu_memory_system_core_sva
    import mcu_memory_system_pkg::*;
(
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    // Host bus and device
    input wire logic              ale,
    input wire logic              rd_n,
    input wire logic              wr_n,
    input wire logic              psen_n,
    input wire logic              low_addr_data_port_oe_n,
    input wire logic              tp_enable,
    input wire logic [N_SEL-1:0]  int_sel,
    input wire logic [1:0]        flash_busy,
    input wire logic [N_PINS-1:0] pin_oe_n,
    input wire logic              power_down
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] busy_cnt_r;
    logic [9:0]  idle_cnt_r;
    wire logic   idle = !ale && rd_n && wr_n && psen_n;
    // ====
    // Helper counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt_r <= 11'h000;
            idle_cnt_r <= 10'h000;
        end else begin
            busy_cnt_r <= flash_busy[0] ? busy_cnt_r + 11'h001 : 11'h000;
            // Saturate so a long idle spell never wraps
            idle_cnt_r <= !idle ? 10'h000 :
                          (&idle_cnt_r) ? idle_cnt_r : idle_cnt_r + 10'h001;
        end
    end
    // ====
    // Properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_one_sel; $onehot0(int_sel); endproperty
    a_one_sel: assert property (p_one_sel) else $error("two selects");
    property p_oe_idle;
        (rd_n && psen_n)[*5] |-> low_addr_data_port_oe_n;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("drive no read");
    property p_oe_sel;
        !low_addr_data_port_oe_n |-> (int_sel != '0) || ($past(int_sel) != '0);
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("drive no select");
    property p_cfg_lock;
        !tp_enable[*4] ##0 (psel && penable && pwrite && paddr >= A_BASE)
            |-> pslverr;
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) else $error("config open");
    property p_busy_len;
        $fell(flash_busy[0]) |-> busy_cnt_r inside {[11'h3E6:11'h3EA]};
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length");
    property p_pd_idle; $rose(power_down) |-> idle_cnt_r >= 10'h0FF; endproperty
    a_pd_idle: assert property (p_pd_idle) else $error("early sleep");
    property p_pd_float; power_down && $past(power_down) |-> &pin_oe_n; endproperty
    a_pd_float: assert property (p_pd_float) else $error("pins driven");
    property p_rdata; psel && penable |=> $stable(prdata); endproperty
    a_rdata: assert property (p_rdata) else $error("prdata moved");
    c_busy: cover property ($rose(flash_busy[0]));
    c_pd: cover property ($rose(power_down));
    c_oe: cover property (!low_addr_data_port_oe_n);
    c_err: cover property (psel && penable && pslverr);
endmodule
bind mcu_memory_system_core mcu_memory_system_core_sva
    mcu_memory_system_core_sva_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .psen_n(psen_n),
    .low_addr_data_port_oe_n(low_addr_data_port_oe_n),
    .tp_enable(tp_enable), .int_sel(int_sel), .flash_busy(flash_busy),
    .pin_oe_n(pin_oe_n), .power_down(power_down));
`default_nettype wire

// >>> mcu_memory_system_pkg.sv
`default_nettype none
package mcu_memory_system_pkg;
    // APB byte offsets
    localparam logic [7:0] A_PAGE   = 8'h00;
    localparam logic [7:0] A_PWR    = 8'h04;
    localparam logic [7:0] A_BLK    = 8'h08;
    localparam logic [7:0] A_STAT   = 8'h0C;
    localparam logic [7:0] A_BASE   = 8'h10;
    localparam logic [7:0] A_MODE   = 8'h14;
    localparam logic [7:0] A_PMODE  = 8'h18;
    localparam logic [7:0] A_TSEL   = 8'h28;
    localparam logic [7:0] A_TMSKL  = 8'h2C;
    localparam logic [7:0] A_TMSKH  = 8'h30;
    localparam logic [7:0] A_TMATL  = 8'h34;
    localparam logic [7:0] A_TMATH  = 8'h38;
    localparam logic [7:0] A_TOUT   = 8'h3C;
    // Host register offsets inside the register page
    localparam logic [2:0] H_PAGE   = 3'h0;
    localparam logic [2:0] H_PWR    = 3'h1;
    localparam logic [2:0] H_BLK    = 3'h2;
    localparam logic [2:0] H_STAT   = 3'h3;
    localparam logic [2:0] H_CMD    = 3'h4;
    // Sizes
    localparam int N_PINS  = 52;
    localparam int N_LIN   = 66;
    localparam int N_ULA   = 24;
    localparam int N_TERM  = 136;
    localparam int N_SEL   = 15;
    localparam int N_SYNC  = 73;
    // Select vector layout
    localparam int S_MAIN  = 0;
    localparam int S_BOOT  = 8;
    localparam int S_SRAM  = 12;
    localparam int S_REG   = 13;
    localparam int S_PORT  = 14;
    // Pin positions
    localparam int P_BUSY  = 36;
    localparam int P_FAIL  = 37;
    localparam int P_F0    = 40;
    localparam int P_G0    = 48;
    // Pin modes
    localparam logic [1:0] PM_IN   = 2'h0;
    localparam logic [1:0] PM_OUT  = 2'h1;
    localparam logic [1:0] PM_ULA  = 2'h2;
    localparam logic [1:0] PM_ADDR = 2'h3;
    // Mode bits
    localparam int M_NONMUX = 0;
    localparam int M_TPEN   = 1;
    localparam int M_APDEN  = 2;
    // Reset values
    localparam logic [31:0] BASE_RST = 32'hFF_02_01_00;
    localparam logic [4:0]  TOUT_RST = 5'h1F;
    // Timing counts
    localparam logic [15:0] FLASH_CYCLES = 16'h03E8;
    localparam logic [15:0] IDLE_CYCLES  = 16'h0100;
endpackage
`default_nettype wire

// >>> tb_top.sv
`default_nettype none
module tb_top
    import mcu_memory_system_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              pclk = 1'b0;
    logic              presetn, psel, penable, pwrite, pready, pslverr;
    logic              tp_enable, ale, rd_n, wr_n, psen_n, oe_n, power_down;
    logic [7:0]        paddr, lad_i, lad_o, hi, mem_rdata;
    logic [31:0]       pwdata, prdata;
    logic [N_SEL-1:0]  int_sel;
    logic [1:0]        flash_busy;
    logic [N_PINS-1:0] pin_o, pin_oe_n;
    logic [N_ULA-1:0]  ula_out;
    int                miscompares, checked;
    logic [7:0]        pg [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01,
                                  8'h01, 8'h00};
    logic [15:0]       ad [7] = '{16'h2000, 16'hA000, 16'hF000, 16'h5000,
                                  16'h7000, 16'h8000, 16'h5000};
    int                ix [7] = '{12, 2, 7, 9, 11, -1, -1};
    always #20 pclk = ~pclk;
    mcu_memory_system_core mcu_memory_system_core_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ale(ale), .rd_n(rd_n),
        .wr_n(wr_n), .psen_n(psen_n), .low_addr_data_port_i(lad_i),
        .low_addr_data_port_o(lad_o), .low_addr_data_port_oe_n(oe_n),
        .high_addr_port(hi), .tp_enable(tp_enable), .mem_rdata(mem_rdata),
        .int_sel(int_sel), .flash_busy(flash_busy), .pin_i(pin_o),
        .pin_o(pin_o), .pin_oe_n(pin_oe_n), .ula_out(ula_out),
        .power_down(power_down));
    host_mcu_model host_mcu_model_inst (
        .pclk(pclk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .psen_n(psen_n),
        .lad(lad_i), .hi(hi), .lad_o(lad_o), .lad_oe_n(oe_n), .sel(int_sel));
    // ====
    // Tasks
    task automatic test_done();
        if (miscompares == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(32'(pready), 32'h1);
        if (pready !== 1'b1) test_done();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk(32'(e), 32'(ee));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [31:0] m);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, exp);
    endtask
    task automatic hchk(input logic [15:0] a, input int idx, input logic [7:0] x);
        logic [7:0]       d;
        logic [N_SEL-1:0] s;
        logic [N_SEL-1:0] es = '0;
        logic             ok;
        if (idx >= 0) es[idx] = 1'b1;
        host_mcu_model_inst.rd(a, d, s, ok);
        chk(32'(s), 32'(es));
        chk(32'(ok), 32'(idx >= 0));
        if (idx >= 0) chk(32'(d), 32'(x));
    endtask
    task automatic wait_busy(input logic [1:0] exp, input int lim);
        int n = 0;
        while (flash_busy !== exp && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(flash_busy), 32'(exp));
        if (flash_busy !== exp) test_done();
    endtask
    // ====
    // Sequence
    initial begin
        {presetn, psel, penable, pwrite, tp_enable} = 5'h00;
        {paddr, pwdata, mem_rdata} = {40'h0, 8'h5A};
        {miscompares, checked} = {32'h0, 32'h0};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(A_BASE, BASE_RST, 32'hFFFFFFFF);
        rd(A_STAT, 32'h1, 32'h1F);
        wr(A_PAGE, 32'hA5, 1'b0);
        rd(A_PAGE, 32'hA5, 32'hFF);
        wr(A_BASE, 32'h0, 1'b1);
        rd(A_BASE, BASE_RST, 32'hFFFFFFFF);
        hchk(16'hFF00, S_REG, 8'hA5);
        host_mcu_model_inst.wr(16'hFF01, 8'h00);
        host_mcu_model_inst.wr(16'hFF02, 8'h3C);
        rd(A_STAT, 32'h0, 32'h1);
        rd(A_BLK, 32'h3C, 32'hFF);
        host_mcu_model_inst.wr(16'hFF04, 8'h01);
        wait_busy(2'b01, 20);
        hchk(16'h2000, S_SRAM, 8'h5A);
        host_mcu_model_inst.wr(16'hFF04, 8'h01);
        rd(A_STAT, 32'hA, 32'hF);
        host_mcu_model_inst.wr(16'hFF04, 8'h02);
        wait_busy(2'b11, 20);
        for (int i = 0; i < 7; i++) begin
            wr(A_PAGE, 32'(pg[i]), 1'b0);
            hchk(ad[i], ix[i], 8'h5A);
        end
        wait_busy(2'b00, 1100);
        host_mcu_model_inst.wr(16'hFF04, 8'h01);
        wait_busy(2'b01, 20);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'(flash_busy), 32'h0);
        presetn <= 1'b1;
        tp_enable <= 1'b1;
        repeat (4) @(posedge pclk);
        wr(A_BASE, 32'hFF020103, 1'b0);
        rd(A_BASE, 32'hFF020103, 32'hFFFFFFFF);
        wr(A_TOUT, 32'h5, 1'b0);
        rd(A_TOUT, 32'h5, 32'h1F);
        chk(32'(ula_out), 32'h20);
        wr(A_PWR, 32'h0, 1'b0);
        wr(A_TOUT, 32'h6, 1'b0);
        rd(A_TOUT, 32'h6, 32'h1F);
        chk(32'(ula_out), 32'h20);
        wr(A_MODE, 32'h4, 1'b0);
        wr(A_PMODE, 32'h5, 1'b0);
        rd(A_PMODE, 32'h5, 32'hFFFFFFFF);
        chk(32'(pin_oe_n[1:0]), 32'h0);
        for (int n = 0; n < 400 && power_down !== 1'b1; n++) @(posedge pclk);
        @(posedge pclk);
        chk(32'(power_down), 32'h1);
        chk(32'(&pin_oe_n), 32'h1);
        test_done();
    end
endmodule
`default_nettype wire
